// ### hw/dlc_pkg.sv
// Purpose: shared constants, types and register map of the capture sequencer
// Assumes: 100 MHz clock, byte addresses on the register bus
// Notes: times are in ms unless named otherwise
`default_nettype none
package dlc_pkg;
  localparam int CLK_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_NS;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_PERIOD = 8'h04;
  localparam logic [7:0] A_MODE = 8'h08;
  localparam logic [7:0] A_ACTIVE = 8'h0C;
  localparam logic [7:0] A_IDLE = 8'h10;
  localparam logic [7:0] A_GATHER = 8'h14;
  localparam logic [7:0] A_SLIM = 8'h18;
  localparam logic [7:0] A_TLIM = 8'h1C;
  localparam logic [7:0] A_PLIM = 8'h20;
  localparam logic [7:0] A_MOTION = 8'h24;
  localparam logic [7:0] A_STATUS = 8'h28;
  localparam logic [7:0] A_COUNT = 8'h2C;
  localparam logic [7:0] A_TIME = 8'h30;
  localparam logic [7:0] A_COLOR = 8'h34;
  localparam logic [7:0] A_TPL = 8'h38;
  localparam logic [7:0] A_TLEN = 8'h3C;
  localparam logic [7:0] A_DROP = 8'h40;
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP = 1;
  localparam int PER_AUTO = 16;
  localparam int MODE_PER = 0;
  localparam int MODE_BIN = 1;
  localparam int MODE_HDR = 2;
  localparam int MODE_POL = 4;
  localparam int MODE_BEG = 8;
  localparam int MODE_END = 12;
  localparam logic [31:0] RST_PERIOD = 32'h0001_0000;
  localparam logic [31:0] RST_MODE = 32'h0000_3204;
  localparam logic [31:0] RST_ACTIVE = 32'h0000_1388;
  localparam logic [31:0] RST_IDLE = 32'h0000_1388;
  localparam logic [31:0] RST_GATHER = 32'h0000_0000;
  localparam logic [31:0] RST_SLIM = 32'h0000_0064;
  localparam logic [31:0] RST_TLIM = 32'h0000_1388;
  localparam logic [31:0] RST_PLIM = 32'h0000_0001;
  localparam logic [31:0] RST_MOTION = 32'h012C_01F4;
  localparam int TPL_DEPTH = 16;
  localparam int RST_TPL_LEN = 8;
  localparam logic [63:0] RST_TPL = "%d %t %q";
  localparam logic [7:0] PCT = 8'h25;
  localparam logic [15:0] AUTO_MS_PER_TOKEN = 16'h0002;
  localparam logic [15:0] LED_FRAME_MS = 16'h07D0;
  localparam logic [15:0] LED_PULSE_MS = 16'h0064;
  localparam logic [15:0] FLASH_MS = 16'h0032;
  localparam logic [6:0] LOW_BATT_PCT = 7'h05;
  localparam logic [2:0] LED_OFF = 3'h0;
  localparam logic [2:0] LED_BLUE = 3'h1;
  localparam logic [2:0] LED_GREEN = 3'h2;
  localparam logic [2:0] LED_RED = 3'h4;
  localparam logic [2:0] LED_YELLOW = 3'h6;
  localparam logic [3:0] TRG_CMD = 4'h0;
  localparam logic [3:0] TRG_POWERUP = 4'h1;
  localparam logic [3:0] TRG_ALWAYS = 4'h1;
  localparam logic [3:0] TRG_LEFT = 4'h2;
  localparam logic [3:0] TRG_RIGHT = 4'h3;
  localparam logic [3:0] TRG_BOTH = 4'h4;
  localparam logic [3:0] TRG_MOTION = 4'h5;
  localparam logic [3:0] TRG_COUNT = 4'h6;
  localparam logic [3:0] TRG_DURATION = 4'h7;
  localparam logic [3:0] TRG_PERIODS = 4'h8;
  localparam logic [1:0] POL_APPEND = 2'h0;
  localparam logic [1:0] POL_REPLACE = 2'h1;
  localparam logic [1:0] POL_NEW = 2'h2;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_RUN = 2'b01, ST_GATHER = 2'b11} dlc_state_t;
  typedef struct packed {
    logic valid;
    logic token;
    logic [7:0] chr;
    logic [7:0] sub;
  } dlc_rec_t;
  typedef struct packed {
    logic open;
    logic truncate;
    logic header;
    logic [15:0] number;
  } dlc_log_t;
endpackage
`default_nettype wire

// ### hw/dlc_sequencer.sv
// Purpose: capture session sequencer with pacing, formatter walk and status LED
// Assumes: pins are asynchronous; accel_mg, battery_pct, rtc_time, rec_ready on clk
// Notes: register bus is Avalon-MM, one wait state per access
// Contract
// - sample at the configured period in ms
// - skip samples when the record path is busy
// - automatic period follows data per sample
// - period zero samples as fast as possible
// - continuous style records the whole session
// - periodic style alternates capture and rest phases
// - keep gathering for the post-stop time
// - template literals, percent tokens, doubled percent
// - ascii keeps literals, binary drops them
// - append keeps one log, replace keeps last period
// - new mode numbers logs, continuous gives one
// - header line at top of each log if enabled
// - defaults: auto, continuous, left start, right stop
// - defaults: 100 samples, 1 period, 5000 ms, 0
// - default motion levels 0.5 g and 0.3 g
// - idle blue or custom, session yellow
// - green flash on every sample
// - red double pulse on card fault
// - red single pulse on low battery
// - usb charging yellow pulse, full green pulse
// - time set and read back through clock chip
// - selectable session start events
// - selectable session stop events
// - usb attach ends session, card to host
//
// Design decisions made here: the address map and the Avalon-MM interface to the registers.
`default_nettype none
module dlc_sequencer
  import dlc_pkg::*;
#(
  parameter int MS_CYC = dlc_pkg::MS_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic btn_left,
  input wire logic btn_right,
  input wire logic card_present,
  input wire logic card_fault,
  input wire logic usb_attached,
  input wire logic usb_power,
  input wire logic batt_charging,
  input wire logic batt_full,
  input wire logic [6:0] battery_pct,
  input wire logic [15:0] accel_mg,
  input wire logic [31:0] rtc_time,
  input wire logic rec_ready,
  output logic sample_take,
  output dlc_pkg::dlc_rec_t rec,
  output dlc_pkg::dlc_log_t log_ctl,
  output logic card_to_host,
  output logic rtc_set_valid,
  output logic [31:0] rtc_set_data,
  output logic [2:0] led_rgb
);
  import dlc_pkg::*;

  logic [7:0] pin_raw;
  logic [7:0] pin_m;
  logic [7:0] pin_s;
  logic [1:0] btn_d;
  logic [31:0] cfg_period, cfg_mode, cfg_active, cfg_idle, cfg_gather;
  logic [31:0] cfg_slim, cfg_tlim, cfg_plim, cfg_motion;
  logic [2:0] cfg_color;
  logic [7:0] tpl [TPL_DEPTH];
  logic [4:0] tpl_len;
  logic cmd_start, cmd_stop;
  dlc_state_t state;
  logic [31:0] pre_cnt, sess_ms, phase_ms, gather_ms, period_cnt;
  logic [31:0] sample_cnt, drop_cnt;
  logic [15:0] per_ms, led_ms, flash_ms;
  logic phase_act, powerup_used, stop_armed, fbusy;
  logic [4:0] fidx;
  logic tick, start_evt, stop_evt, start_go, capturing, due, take;
  logic [15:0] eff_period, auto_period;
  logic [4:0] tok_cnt;
  logic [7:0] c0, c1, c2;
  logic [31:0] next_rdata;
  logic [2:0] next_led;
  logic wr;

  // named views of the mode word and of the synchronised pins
  wire logic periodic = cfg_mode[MODE_PER];
  wire logic binary = cfg_mode[MODE_BIN];
  wire logic [1:0] pol = cfg_mode[MODE_POL +: 2];
  wire logic [3:0] beg_trg = {1'b0, cfg_mode[MODE_BEG +: 3]};
  wire logic [3:0] end_trg = cfg_mode[MODE_END +: 4];
  wire logic usb_s = pin_s[4];
  wire logic card_err = !pin_s[2] || pin_s[3];

  function automatic logic btn_hit(input logic [3:0] trg, input logic [1:0] b);
    case (trg)
      TRG_LEFT: btn_hit = b[0];
      TRG_RIGHT: btn_hit = b[1];
      TRG_BOTH: btn_hit = b[0] && b[1];
      default: btn_hit = 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] tch(input logic [4:0] i);
    tch = (i < tpl_len) ? tpl[i[3:0]] : 8'h00;
  endfunction

  // pins cross into clk through two flops before use
  assign pin_raw = {batt_full, batt_charging, usb_power, usb_attached,
                    card_fault, card_present, btn_right, btn_left};
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      pin_m <= 8'h00;
      pin_s <= 8'h00;
      btn_d <= 2'h0;
    end
    else
    begin
      pin_m <= pin_raw;
      pin_s <= pin_m;
      btn_d <= pin_s[1:0];
    end

  // shared ms tick, restarted with each session
  assign tick = (pre_cnt == 32'(MS_CYC - 1));
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      pre_cnt <= 32'h0;
    else if (start_go || tick)
      pre_cnt <= 32'h0;
    else
      pre_cnt <= pre_cnt + 32'h1;

  always_comb
  begin
    start_evt = cmd_start;
    case (beg_trg)
      TRG_POWERUP: start_evt = start_evt || !powerup_used;
      TRG_LEFT, TRG_RIGHT, TRG_BOTH:
        start_evt = start_evt || (btn_hit(beg_trg, pin_s[1:0]) && !btn_hit(beg_trg, btn_d));
      TRG_MOTION: start_evt = start_evt || (accel_mg > cfg_motion[15:0]);
      default: start_evt = start_evt;
    endcase
    start_evt = start_evt && !usb_s;
    stop_evt = cmd_stop;
    case (end_trg)
      TRG_ALWAYS: stop_evt = 1'b1;
      TRG_LEFT, TRG_RIGHT, TRG_BOTH:
        stop_evt = stop_evt || (btn_hit(end_trg, pin_s[1:0]) && stop_armed);
      TRG_MOTION: stop_evt = stop_evt || (accel_mg < cfg_motion[31:16]);
      TRG_COUNT: stop_evt = stop_evt || (sample_cnt >= cfg_slim);
      TRG_DURATION: stop_evt = stop_evt || (sess_ms >= cfg_tlim);
      TRG_PERIODS: stop_evt = stop_evt || (periodic && period_cnt >= cfg_plim);
      default: stop_evt = stop_evt;
    endcase
  end
  assign start_go = (state == ST_IDLE) && start_evt;

  // session sequencing and log file control
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      state <= ST_IDLE;
      sess_ms <= 32'h0;
      phase_ms <= 32'h0;
      gather_ms <= 32'h0;
      period_cnt <= 32'h0;
      phase_act <= 1'b0;
      powerup_used <= 1'b0;
      stop_armed <= 1'b0;
      card_to_host <= 1'b0;
      log_ctl <= '0;
    end
    else
    begin
      card_to_host <= usb_s;
      log_ctl.open <= 1'b0;
      case (state)
        ST_IDLE:
          if (start_go)
          begin
            state <= ST_RUN;
            sess_ms <= 32'h0;
            phase_ms <= 32'h0;
            period_cnt <= 32'h0;
            phase_act <= 1'b1;
            powerup_used <= 1'b1;
            stop_armed <= 1'b0;
            log_ctl <= '{open: 1'b1, truncate: 1'b1, header: cfg_mode[MODE_HDR],
                         number: 16'h0001};
          end
        ST_RUN:
        begin
          if (!btn_hit(end_trg, pin_s[1:0]))
            stop_armed <= 1'b1;
          if (usb_s)
            state <= ST_IDLE;
          else if (stop_evt)
          begin
            state <= (cfg_gather == 32'h0) ? ST_IDLE : ST_GATHER;
            gather_ms <= 32'h0;
          end
          else if (tick)
          begin
            sess_ms <= sess_ms + 32'h1;
            if (periodic && phase_act && phase_ms + 32'h1 >= cfg_active)
            begin
              phase_act <= 1'b0;
              phase_ms <= 32'h0;
              period_cnt <= period_cnt + 32'h1;
            end
            else if (periodic && !phase_act && phase_ms + 32'h1 >= cfg_idle)
            begin
              phase_act <= 1'b1;
              phase_ms <= 32'h0;
              if (pol == POL_NEW)
                log_ctl <= '{open: 1'b1, truncate: 1'b1, header: cfg_mode[MODE_HDR],
                             number: log_ctl.number + 16'h0001};
              else if (pol == POL_REPLACE)
                log_ctl <= '{open: 1'b1, truncate: 1'b1, header: cfg_mode[MODE_HDR],
                             number: log_ctl.number};
            end
            else if (periodic)
              phase_ms <= phase_ms + 32'h1;
          end
        end
        ST_GATHER:
          if (usb_s)
            state <= ST_IDLE;
          else if (tick)
          begin
            gather_ms <= gather_ms + 32'h1;
            if (gather_ms + 32'h1 >= cfg_gather)
              state <= ST_IDLE;
          end
        default: state <= ST_IDLE;
      endcase
    end

  // pacing; auto period grows with the number of tokens per record
  always_comb
  begin
    tok_cnt = 5'h00;
    for (int i = 0; i < TPL_DEPTH; i++)
      if (tpl[i] == PCT && 5'(i) < tpl_len)
        tok_cnt = tok_cnt + 5'h01;
    auto_period = {11'h000, tok_cnt} * AUTO_MS_PER_TOKEN + 16'h0001;
    eff_period = cfg_period[PER_AUTO] ? auto_period : cfg_period[15:0];
    capturing = (state == ST_RUN && (!periodic || phase_act)) || state == ST_GATHER;
    due = capturing && (eff_period == 16'h0000 || (tick && per_ms + 16'h0001 >= eff_period));
  end
  assign take = due && !fbusy;

  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      per_ms <= 16'h0000;
      sample_take <= 1'b0;
      sample_cnt <= 32'h0;
      drop_cnt <= 32'h0;
    end
    else if (start_go)
    begin
      per_ms <= 16'h0000;
      sample_take <= 1'b0;
      sample_cnt <= 32'h0;
      drop_cnt <= 32'h0;
    end
    else
    begin
      sample_take <= take;
      if (take)
        sample_cnt <= sample_cnt + 32'h1;
      // a late record costs a sample, never the pacing
      if (due && fbusy && eff_period != 16'h0000)
        drop_cnt <= drop_cnt + 32'h1;
      if (tick && capturing)
        per_ms <= (per_ms + 16'h0001 >= eff_period) ? 16'h0000 : per_ms + 16'h0001;
    end

  // template walk, one item per accepted record
  // a process, so a template write re-reads the characters even when fidx holds
  always_comb
  begin
    c0 = tch(fidx);
    c1 = tch(5'(fidx + 5'h01));
    c2 = tch(5'(fidx + 5'h02));
  end
  wire logic two_letter = (c1 == "u" || c1 == "n" || c1 == "c" || c1 == "r");

  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      fbusy <= 1'b0;
      fidx <= 5'h00;
      rec <= '0;
    end
    else if (take)
    begin
      fbusy <= 1'b1;
      fidx <= 5'h00;
    end
    else if (fbusy && (!rec.valid || rec_ready))
    begin
      if (fidx >= tpl_len)
      begin
        fbusy <= 1'b0;
        rec.valid <= 1'b0;
      end
      else if (c0 != PCT)
      begin
        rec <= '{valid: !binary, token: 1'b0, chr: c0, sub: 8'h00};
        fidx <= 5'(fidx + 5'h01);
      end
      else if (c1 == PCT)
      begin
        rec <= '{valid: !binary, token: 1'b0, chr: PCT, sub: 8'h00};
        fidx <= 5'(fidx + 5'h02);
      end
      else if (two_letter)
      begin
        rec <= '{valid: 1'b1, token: 1'b1, chr: c1, sub: c2};
        fidx <= 5'(fidx + 5'h03);
      end
      else
      begin
        rec <= '{valid: 1'b1, token: 1'b1, chr: c1, sub: 8'h00};
        fidx <= 5'(fidx + 5'h02);
      end
    end

  // status LED; pulses overlay the steady colour
  wire logic dbl = led_ms < LED_PULSE_MS
    || (led_ms >= 16'(LED_PULSE_MS * 2) && led_ms < 16'(LED_PULSE_MS * 3));
  wire logic sgl = led_ms < LED_PULSE_MS;
  always_comb
  begin
    if (card_err && dbl)
      next_led = LED_RED;
    else if (card_err && !dbl && sgl)
      next_led = LED_OFF;
    else if (!pin_s[5] && battery_pct <= LOW_BATT_PCT && sgl)
      next_led = LED_RED;
    else if (pin_s[5] && pin_s[6] && sgl)
      next_led = LED_YELLOW;
    else if (pin_s[5] && pin_s[7] && sgl)
      next_led = LED_GREEN;
    else if (state == ST_IDLE)
      next_led = cfg_color;
    else if (flash_ms != 16'h0000)
      next_led = LED_GREEN;
    else
      next_led = LED_YELLOW;
  end

  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      led_ms <= 16'h0000;
      flash_ms <= 16'h0000;
      led_rgb <= LED_OFF;
    end
    else
    begin
      led_rgb <= next_led;
      if (tick)
        led_ms <= (led_ms + 16'h0001 >= LED_FRAME_MS) ? 16'h0000 : led_ms + 16'h0001;
      if (sample_take)
        flash_ms <= FLASH_MS;
      else if (tick && flash_ms != 16'h0000)
        flash_ms <= flash_ms - 16'h0001;
    end

  // register bus: one wait state, data ready on the accepting edge
  assign wr = avs_write && !avs_waitrequest;
  always_comb
  begin
    case (avs_address)
      A_PERIOD: next_rdata = cfg_period;
      A_MODE: next_rdata = cfg_mode;
      A_ACTIVE: next_rdata = cfg_active;
      A_IDLE: next_rdata = cfg_idle;
      A_GATHER: next_rdata = cfg_gather;
      A_SLIM: next_rdata = cfg_slim;
      A_TLIM: next_rdata = cfg_tlim;
      A_PLIM: next_rdata = cfg_plim;
      A_MOTION: next_rdata = cfg_motion;
      A_STATUS: next_rdata = {log_ctl.number, 10'h000, card_to_host, fbusy,
                              phase_act, state == ST_RUN, state == ST_GATHER, state != ST_IDLE};
      A_COUNT: next_rdata = sample_cnt;
      A_TIME: next_rdata = rtc_time;
      A_COLOR: next_rdata = {29'h0, cfg_color};
      A_TLEN: next_rdata = {27'h0, tpl_len};
      A_DROP: next_rdata = drop_cnt;
      default: next_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end
    else
    begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest)
        avs_readdata <= next_rdata;
    end

  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      cfg_period <= RST_PERIOD;
      cfg_mode <= RST_MODE;
      cfg_active <= RST_ACTIVE;
      cfg_idle <= RST_IDLE;
      cfg_gather <= RST_GATHER;
      cfg_slim <= RST_SLIM;
      cfg_tlim <= RST_TLIM;
      cfg_plim <= RST_PLIM;
      cfg_motion <= RST_MOTION;
      cfg_color <= LED_BLUE;
      tpl_len <= 5'(RST_TPL_LEN);
      for (int i = 0; i < TPL_DEPTH; i++)
        tpl[i] <= (i < RST_TPL_LEN) ? RST_TPL[8 * (RST_TPL_LEN - 1 - i) +: 8] : 8'h00;
      cmd_start <= 1'b0;
      cmd_stop <= 1'b0;
      rtc_set_valid <= 1'b0;
      rtc_set_data <= 32'h0;
    end
    else
    begin
      cmd_start <= wr && avs_address == A_CTRL && avs_writedata[CTRL_START];
      cmd_stop <= wr && avs_address == A_CTRL && avs_writedata[CTRL_STOP];
      rtc_set_valid <= wr && avs_address == A_TIME;
      if (wr)
        case (avs_address)
          A_PERIOD: cfg_period <= avs_writedata & 32'h0001_FFFF;
          A_MODE: cfg_mode <= avs_writedata;
          A_ACTIVE: cfg_active <= avs_writedata;
          A_IDLE: cfg_idle <= avs_writedata;
          A_GATHER: cfg_gather <= avs_writedata;
          A_SLIM: cfg_slim <= avs_writedata;
          A_TLIM: cfg_tlim <= avs_writedata;
          A_PLIM: cfg_plim <= avs_writedata;
          A_MOTION: cfg_motion <= avs_writedata;
          A_TIME: rtc_set_data <= avs_writedata;
          A_COLOR: cfg_color <= avs_writedata[2:0];
          A_TPL: tpl[avs_writedata[11:8]] <= avs_writedata[7:0];
          A_TLEN: tpl_len <= (avs_writedata[4:0] > 5'(TPL_DEPTH)) ? 5'(TPL_DEPTH)
                                                                    : avs_writedata[4:0];
          default: cfg_color <= cfg_color;
        endcase
    end

  // checks
  property p_take_cause;
    @(posedge clk) disable iff (!reset_n) sample_take |-> $past(capturing);
  endproperty
  a_take_cause: assert property (p_take_cause) else $error("sample outside capture");
  property p_drop;
    @(posedge clk) disable iff (!reset_n)
      (due && fbusy && eff_period != 16'h0000 && !start_go)
      |=> drop_cnt == $past(drop_cnt) + 32'h1;
  endproperty
  a_drop: assert property (p_drop) else $error("skipped sample not counted");
  property p_zero;
    @(posedge clk) disable iff (!reset_n)
      (eff_period == 16'h0000 && capturing && !fbusy && !start_go) |=> sample_take;
  endproperty
  a_zero: assert property (p_zero) else $error("period zero did not sample");
  property p_rest;
    @(posedge clk) disable iff (!reset_n)
      (state == ST_RUN && periodic && !phase_act)[*2] |-> !sample_take;
  endproperty
  a_rest: assert property (p_rest) else $error("sample during rest");
  property p_gather_end;
    @(posedge clk) disable iff (!reset_n)
      (state == ST_GATHER && !usb_s && tick && gather_ms + 32'h1 >= cfg_gather)
      |=> state == ST_IDLE;
  endproperty
  a_gather_end: assert property (p_gather_end) else $error("gather overran");
  property p_pct;
    @(posedge clk) disable iff (!reset_n)
      (fbusy && !take && (!rec.valid || rec_ready) && fidx < tpl_len && c0 == PCT
       && c1 == PCT && !binary) |=> rec.valid && !rec.token && rec.chr == PCT;
  endproperty
  a_pct: assert property (p_pct) else $error("doubled percent lost");
  property p_binary;
    @(posedge clk) disable iff (!reset_n)
      (binary && $stable(binary) && $rose(rec.valid)) |-> rec.token;
  endproperty
  a_binary: assert property (p_binary) else $error("literal in binary mode");
  property p_first_log;
    @(posedge clk) disable iff (!reset_n)
      start_go |=> log_ctl.open && log_ctl.number == 16'h0001 && state == ST_RUN;
  endproperty
  a_first_log: assert property (p_first_log) else $error("first log not number one");
  property p_usb;
    @(posedge clk) disable iff (!reset_n)
      (usb_s && state != ST_IDLE) |=> state == ST_IDLE ##1 card_to_host;
  endproperty
  a_usb: assert property (p_usb) else $error("usb did not end session");
endmodule
`default_nettype wire

// ### verification/dlc_card_model.sv
// Purpose: storage path and card slot on the far side of the sequencer
// Assumes: records are accepted on clk
// Notes: stall halves the accept rate to push the formatter
`default_nettype none
module dlc_card_model
  import dlc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic stall,
  input wire dlc_pkg::dlc_rec_t rec,
  output logic rec_ready,
  output logic card_present
);
  timeunit 1ns;
  timeprecision 1ps;
  // card always seated, so the led stays out of the error pattern
  assign card_present = 1'b1;
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      rec_ready <= 1'b0;
    else
      rec_ready <= stall ? ~rec_ready : 1'b1;
endmodule
`default_nettype wire

// ### verification/datalog_capture_sequencer_bench.sv
// Purpose: self-checking bench for the capture sequencer
// Assumes: one ms shortened to 10 clocks
// Notes: no random stimulus
`default_nettype none
module datalog_capture_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import dlc_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, stall = 1'b0;
  logic btn_left = 1'b0, btn_right = 1'b0, usb_attached = 1'b0, card_fault = 1'b0;
  logic usb_power = 1'b0, batt_charging = 1'b0, batt_full = 1'b0;
  logic [6:0] battery_pct = 7'h64;
  logic [15:0] accel_mg = 16'h0000;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0, rtc_time = 32'h0ABC, q, avs_readdata, rtc_set_data;
  logic avs_waitrequest, card_present, rec_ready, sample_take, card_to_host, rtc_set_valid;
  logic [2:0] led_rgb;
  dlc_rec_t rec;
  dlc_log_t log_ctl;
  int n_fail = 0, checks = 0, cyc = 0, gap;
  logic [7:0] da [10] = '{A_PERIOD, A_MODE, A_ACTIVE, A_IDLE, A_GATHER, A_SLIM, A_TLIM,
    A_PLIM, A_MOTION, 8'h44};
  logic [31:0] dv [10] = '{32'h0001_0000, 32'h3204, 32'h1388, 32'h1388, 32'h0, 32'h64,
    32'h1388, 32'h1, 32'h012C_01F4, 32'h0};
  always #5 clk = ~clk;
  dlc_sequencer #(.MS_CYC(10)) dut (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .btn_left(btn_left),
    .btn_right(btn_right), .card_present(card_present), .card_fault(card_fault),
    .usb_attached(usb_attached), .usb_power(usb_power), .batt_charging(batt_charging),
    .batt_full(batt_full), .battery_pct(battery_pct), .accel_mg(accel_mg),
    .rtc_time(rtc_time), .rec_ready(rec_ready), .sample_take(sample_take), .rec(rec),
    .log_ctl(log_ctl), .card_to_host(card_to_host), .rtc_set_valid(rtc_set_valid),
    .rtc_set_data(rtc_set_data), .led_rgb(led_rgb));
  dlc_card_model partner (.clk(clk), .reset_n(reset_n), .stall(stall), .rec(rec),
    .rec_ready(rec_ready), .card_present(card_present));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // holds the request until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wait_take;
    gap = 0;
    do
    begin
      @(negedge clk);
      gap++;
    end
    while (sample_take !== 1'b1);
  endtask
  // button held long enough to pass the pin synchroniser
  task automatic press(input logic left);
    @(posedge clk);
    if (left)
      btn_left <= 1'b1;
    else
      btn_right <= 1'b1;
    repeat (10) @(posedge clk);
    btn_left <= 1'b0;
    btn_right <= 1'b0;
    bus(1'b0, A_STATUS, 32'h0);
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      test_done();
    end
  end
  task automatic t_defaults;
    for (int i = 0; i < 10; i++)
    begin
      bus(1'b0, da[i], 32'h0);
      chk(q, dv[i]);
    end
    chk(led_rgb, 3'h1);
    bus(1'b1, A_TIME, 32'h1234_5678);
    @(negedge clk);
    chk(rtc_set_valid, 1'b1);
    chk(rtc_set_data, 32'h1234_5678);
    bus(1'b0, A_TIME, 32'h0);
    chk(q, 32'h0ABC);
  endtask
  task automatic t_continuous;
    bus(1'b1, A_PERIOD, 32'h64);
    bus(1'b1, A_CTRL, 32'h1);
    wait_take();
    wait_take();
    chk(gap, 1000);
    @(negedge clk);
    chk(rec, {2'b11, "d", 8'h00});
    @(negedge clk);
    chk(rec, {2'b10, " ", 8'h00});
    repeat (3) @(negedge clk);
    chk(led_rgb, 3'h2);
    repeat (600) @(negedge clk);
    chk(led_rgb, 3'h6);
    bus(1'b0, A_COUNT, 32'h0);
    chk(q, 32'h2);
    bus(1'b1, A_CTRL, 32'h2);
    bus(1'b0, A_STATUS, 32'h0);
    chk(q[0], 1'b0);
    chk(q[31:16], 16'h0001);
    chk(led_rgb, 3'h1);
  endtask
  // last pair shares the left button for start and stop
  task automatic t_buttons;
    press(1'b1);
    chk(q[0], 1'b1);
    press(1'b0);
    chk(q[0], 1'b0);
    bus(1'b1, A_MODE, 32'h2204);
    press(1'b1);
    chk(q[0], 1'b1);
    press(1'b1);
    chk(q[0], 1'b0);
  endtask
  // periodic, new logs, 1 ms pacing against a stalled path, stop after 2 periods
  task automatic t_periodic;
    stall <= 1'b1;
    bus(1'b1, A_PERIOD, 32'h1);
    bus(1'b1, A_ACTIVE, 32'h3);
    bus(1'b1, A_IDLE, 32'h2);
    bus(1'b1, A_PLIM, 32'h2);
    bus(1'b1, A_GATHER, 32'h3);
    bus(1'b1, A_MODE, 32'h8025);
    bus(1'b1, A_CTRL, 32'h1);
    repeat (200) @(negedge clk);
    bus(1'b0, A_STATUS, 32'h0);
    chk(q[0], 1'b0);
    chk(q[31:16], 16'h0002);
    bus(1'b0, A_DROP, 32'h0);
    chk(q == 32'h0, 1'b0);
  endtask
  task automatic t_usb;
    bus(1'b1, A_CTRL, 32'h1);
    bus(1'b0, A_STATUS, 32'h0);
    chk(q[0], 1'b1);
    usb_attached <= 1'b1;
    repeat (10) @(posedge clk);
    chk(card_to_host, 1'b1);
    bus(1'b0, A_STATUS, 32'h0);
    chk(q[0], 1'b0);
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    t_defaults();
    t_continuous();
    t_buttons();
    t_periodic();
    t_usb();
    test_done();
  end
endmodule
`default_nettype wire
